// [src/mac_timer_pkg.sv]
package mac_timer_pkg;

   // Special function register location and field positions.
   localparam logic [7:0] CFG_ADDR      = 8'hc3;
   localparam int         BIT_CMP_FLAG  = 7;
   localparam int         BIT_PER_FLAG  = 6;
   localparam int         BIT_OFC_FLAG  = 5;
   localparam int         BIT_CMP_SEL   = 3;
   localparam int         BIT_RSVD      = 2;
   localparam int         BIT_SYNC      = 1;
   localparam int         BIT_RUN       = 0;
   localparam logic [7:0] CFG_RESET     = 8'h02;

   // Restart arithmetic constants.
   localparam int          SLEEP_WIDTH  = 24;
   localparam int          OVH_CYCLES   = 75;
   // Ratio 976.5625 = 15625/16, held with four fraction bits.
   localparam int          RATIO_FRAC   = 4;
   localparam logic [13:0] RATIO_FIXED  = 14'h3d09;
   localparam logic [3:0]  ROUND_HALF   = 4'h8;
   localparam int          CALC_WIDTH   = 44;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] data;
   } sfr_req_s;

   typedef struct packed {
      logic cmpEvent;
      logic perEvent;
      logic ofcEvent;
   } timer_events_s;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_WAIT_GO  = 4'b0010,
      ST_RUN      = 4'b0100,
      ST_WAIT_END = 4'b1000
   } run_state_e;

endpackage

// [src/mac_timer_sync_reload_config.sv]
`timescale 1ns/100ps
module mac_timer_sync_reload_config
   import mac_timer_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clkEn,
   // Special function register access.
   input  wire mac_timer_pkg::sfr_req_s    sfrReq,
   output logic [7:0]                      sfrRdata,
   // Timer datapath interface.
   input  wire mac_timer_pkg::timer_events_s events,
   input  wire logic                       sleepEdge,
   input  wire logic [23:0]                sleepNow,
   input  wire logic [15:0]                timerNow,
   input  wire logic [15:0]                timerPeriod,
   input  wire logic [19:0]                overflowNow,
   output logic                            timerRunning,
   output logic                            compareByteSelect,
   output logic                            reloadStrobe,
   output logic [15:0]                     reloadTimer,
   output logic [19:0]                     reloadOverflow
);
   import mac_timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic            cmpFlag;
   logic            perFlag;
   logic            ofcFlag;
   logic            cmpSel;
   logic            rsvdBit;
   logic            syncEn;
   run_state_e      state;
   logic [6:0]      delayCnt;
   logic [23:0]     sleepStored;
   logic [43:0]     calcRemain;
   logic [19:0]     calcQuot;
   logic [15:0]     calcPeriod;
   logic [5:0]      divStep;
   logic            divBusy;
   logic            cfgWrite;
   logic            cfgRead;
   logic [43:0]     next_count;
   logic [43:0]     trial;

   assign cfgWrite = clkEn && sfrReq.write && sfrReq.addr == CFG_ADDR;
   assign cfgRead  = clkEn && sfrReq.read && sfrReq.addr == CFG_ADDR;

   // Elapsed sleep ticks; a zero or negative difference wraps by 2^24.
   function automatic logic [24:0] elapsedTicks(input logic [23:0] now,
                                                input logic [23:0] prev);
      logic [24:0] diff;
      diff = {1'b0, now} - {1'b0, prev};
      if (now <= prev) begin
         diff = {1'b1, 24'h000000} + {1'b0, now} - {1'b0, prev};
      end
      return diff;
   endfunction

   // Fixed point product is exact, so only the final rounding errs.
   always_comb begin
      logic [24:0] ticks;
      logic [43:0] prod;
      ticks = '0;
      prod = '0;
      ticks = elapsedTicks(sleepNow, sleepStored);
      prod = 44'(ticks) * 44'(RATIO_FIXED);
      prod = prod + 44'(ROUND_HALF) + 44'({timerNow, 4'h0})
             + 44'(OVH_CYCLES << RATIO_FRAC);
      next_count = prod >> RATIO_FRAC;
      trial = calcRemain - (44'(calcPeriod) << divStep);
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flags.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmpFlag <= 1'b0;
         perFlag <= 1'b0;
         ofcFlag <= 1'b0;
      end else if (clkEn) begin
         if (events.cmpEvent) begin
            cmpFlag <= 1'b1;
         end else if (cfgWrite && !sfrReq.data[BIT_CMP_FLAG]) begin
            cmpFlag <= 1'b0;
         end
         if (events.perEvent) begin
            perFlag <= 1'b1;
         end else if (cfgWrite && !sfrReq.data[BIT_PER_FLAG]) begin
            perFlag <= 1'b0;
         end
         if (events.ofcEvent) begin
            ofcFlag <= 1'b1;
         end else if (cfgWrite && !sfrReq.data[BIT_OFC_FLAG]) begin
            ofcFlag <= 1'b0;
         end
      end
   end

   // Plain configuration bits.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmpSel  <= CFG_RESET[BIT_CMP_SEL];
         rsvdBit <= CFG_RESET[BIT_RSVD];
         syncEn  <= CFG_RESET[BIT_SYNC];
      end else if (clkEn && cfgWrite) begin
         cmpSel  <= sfrReq.data[BIT_CMP_SEL];
         rsvdBit <= sfrReq.data[BIT_RSVD];
         syncEn  <= sfrReq.data[BIT_SYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run control. The run bit reads the state, not the last write.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state    <= ST_IDLE;
         delayCnt <= '0;
      end else if (clkEn) begin
         case (state)
            ST_IDLE: begin
               if (cfgWrite && sfrReq.data[BIT_RUN]) begin
                  state <= sfrReq.data[BIT_SYNC] ? ST_WAIT_GO : ST_RUN;
               end
            end
            ST_WAIT_GO: begin
               if (delayCnt != '0) begin
                  delayCnt <= delayCnt - 7'h01;
                  if (delayCnt == 7'h01) begin
                     state <= ST_RUN;
                  end
               end else if (sleepEdge) begin
                  delayCnt <= 7'(OVH_CYCLES);
               end
            end
            ST_RUN: begin
               if (cfgWrite && !sfrReq.data[BIT_RUN]) begin
                  state <= sfrReq.data[BIT_SYNC] ? ST_WAIT_END : ST_IDLE;
               end
            end
            ST_WAIT_END: begin
               if (sleepEdge) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Sleep value saved at each synchronised stop.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sleepStored <= '0;
      end else if (clkEn && state == ST_WAIT_END && sleepEdge) begin
         sleepStored <= sleepNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Restart arithmetic: restoring division of the count by the period,
   // one quotient bit per cycle, well inside the 75 cycle start window.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         calcRemain <= '0;
         calcQuot   <= '0;
         calcPeriod <= '0;
         divStep    <= '0;
         divBusy    <= 1'b0;
      end else if (clkEn) begin
         if (state == ST_WAIT_GO && delayCnt == '0 && sleepEdge) begin
            calcRemain <= next_count;
            calcPeriod <= timerPeriod;
            calcQuot   <= '0;
            // The count stays below 2^34, so 34 quotient steps cover it.
            divStep    <= 6'd33;
            divBusy    <= (timerPeriod != '0);
         end else if (divBusy) begin
            if (!trial[43] && (calcRemain >> divStep) >= 44'(calcPeriod))
            begin
               calcRemain <= trial;
               calcQuot   <= calcQuot | (20'h00001 << divStep);
            end
            if (divStep == '0) begin
               divBusy <= 1'b0;
            end else begin
               divStep <= divStep - 6'd1;
            end
         end
      end
   end

   // Outputs, all registered.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timerRunning      <= 1'b0;
         compareByteSelect <= 1'b0;
         reloadStrobe      <= 1'b0;
         reloadTimer       <= '0;
         reloadOverflow    <= '0;
         sfrRdata          <= '0;
      end else if (clkEn) begin
         timerRunning      <= (state == ST_RUN) || (state == ST_WAIT_END);
         compareByteSelect <= cmpSel;
         reloadStrobe      <= state == ST_WAIT_GO && delayCnt == 7'h01;
         if (state == ST_WAIT_GO && delayCnt == 7'h01) begin
            reloadTimer    <= calcRemain[15:0];
            reloadOverflow <= overflowNow + calcQuot;
         end
         if (cfgRead) begin
            sfrRdata <= {cmpFlag, perFlag, ofcFlag, 1'b0, cmpSel,
                         rsvdBit, syncEn,
                         (state == ST_RUN) || (state == ST_WAIT_END)};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence syncStartSeq;
      clkEn && state == ST_IDLE && cfgWrite && sfrReq.data[BIT_RUN]
      && sfrReq.data[BIT_SYNC];
   endsequence

   sync_start_hold_a: assert property (syncStartSeq ##1 (clkEn && !sleepEdge)
      |=> state == ST_WAIT_GO)
      else $error("Synced start changed state early.");

   start_delay_a: assert property (clkEn && state == ST_WAIT_GO
      && delayCnt == '0 && sleepEdge |-> ##1 delayCnt == 7'd75)
      else $error("Start delay not loaded with 75.");

   immediate_start_a: assert property (clkEn && state == ST_IDLE && cfgWrite
      && sfrReq.data[BIT_RUN] && !sfrReq.data[BIT_SYNC]
      |=> state == ST_RUN)
      else $error("Immediate start failed.");

   stop_store_a: assert property (clkEn && state == ST_WAIT_END && sleepEdge
      |=> state == ST_IDLE && sleepStored == $past(sleepNow))
      else $error("Synced stop did not store sleep value.");

   cmp_set_wins_a: assert property (clkEn && events.cmpEvent && cfgWrite
      |=> cmpFlag)
      else $error("Compare flag lost on clear collision.");

   per_one_keeps_a: assert property (clkEn && !events.perEvent && cfgWrite
      && sfrReq.data[BIT_PER_FLAG] |=> perFlag == $past(perFlag))
      else $error("Writing one changed period flag.");

   ofc_zero_clears_a: assert property (clkEn && !events.ofcEvent && cfgWrite
      && !sfrReq.data[BIT_OFC_FLAG] |=> !ofcFlag)
      else $error("Writing zero left overflow flag set.");

   run_read_a: assert property (cfgRead |=> sfrRdata[BIT_RUN]
      == $past((state == ST_RUN) || (state == ST_WAIT_END)))
      else $error("Run bit read does not show state.");

   select_out_a: assert property (clkEn && cfgWrite ##1 clkEn
      |=> compareByteSelect == $past(sfrReq.data[BIT_CMP_SEL], 2))
      else $error("Compare select not forwarded.");

endmodule

// [testbench/sfr_core_model.sv]
`timescale 1ns/100ps
module sfr_core_model
   import mac_timer_pkg::*;
(
   // Clock.
   input  wire logic                 clk,
   // Register access.
   output mac_timer_pkg::sfr_req_s   sfrReq,
   input  wire logic [7:0]           sfrRdata
);
   import mac_timer_pkg::*;

   initial begin
      sfrReq = '0;
   end

   // The released bus shows inverted address and data, not stale values.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      sfrReq = '{1'b1, 1'b0, addr, data & 8'hfb};
      @(negedge clk);
      sfrReq = '{1'b0, 1'b0, ~addr, ~data};
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      sfrReq = '{1'b0, 1'b1, addr, 8'h5a};
      @(negedge clk);
      sfrReq = '{1'b0, 1'b0, ~addr, 8'ha5};
      data = sfrRdata;
   endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import mac_timer_pkg::*;
   logic          clk, sysRst, runOut, selOut, strobe, clkEn;
   logic [7:0]    rdata, got;
   logic [23:0]   sleepNow, stored;
   logic [15:0]   timerNow, period, relT;
   logic [19:0]   ovfNow, relO;
   logic          sleepEdge;
   sfr_req_s      req;
   timer_events_s ev;
   int            fail_count, checked, cyc, n;
   longint        c;
   int            deltas[3] = '{1, 32, 0};

   mac_timer_sync_reload_config u_dut (.clk(clk), .sys_rst(sysRst),
      .clkEn(clkEn), .sfrReq(req), .sfrRdata(rdata), .events(ev),
      .sleepEdge(sleepEdge), .sleepNow(sleepNow), .timerNow(timerNow),
      .timerPeriod(period), .overflowNow(ovfNow), .timerRunning(runOut),
      .compareByteSelect(selOut), .reloadStrobe(strobe),
      .reloadTimer(relT), .reloadOverflow(relO));
   sfr_core_model u_core (.clk(clk), .sfrReq(req), .sfrRdata(rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string name, input logic [19:0] exp,
                        input logic [19:0] seen);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rcheck(input logic [7:0] exp);
      u_core.rd(CFG_ADDR, got);
      check("config", {12'h000, exp}, {12'h000, got});
   endtask

   task automatic pulse_edge();
      @(negedge clk);
      sleepEdge = 1'b1;
      @(negedge clk);
      sleepEdge = 1'b0;
   endtask

   task automatic print_verdict();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sysRst = 1'b1; ev = '0; sleepEdge = 1'b0; sleepNow = 24'h000100;
      clkEn = 1'b1;
      timerNow = 16'h0123; period = 16'h0140; ovfNow = 20'hffff0;
      repeat (4) @(negedge clk);
      sysRst = 1'b0;
      rcheck(CFG_RESET);
      // Flags set by events, kept on a write of ones, cleared by zeros.
      @(negedge clk); ev = 3'b111;
      @(negedge clk); ev = 3'b000;
      rcheck(8'he2);
      u_core.wr(CFG_ADDR, 8'he2);
      rcheck(8'he2);
      u_core.wr(CFG_ADDR, 8'h02);
      rcheck(8'h02);
      fork
         u_core.wr(CFG_ADDR, 8'h02);
         begin @(negedge clk); ev = 3'b100; @(negedge clk); ev = 3'b000; end
      join
      rcheck(8'h82);
      u_core.wr(8'hc4, 8'h00);
      u_core.rd(8'hc4, got);
      check("unmapped", 20'h00082, {12'h000, got});
      // A write while the clock enable is low must leave everything as is.
      clkEn = 1'b0;
      u_core.wr(CFG_ADDR, 8'h00);
      clkEn = 1'b1;
      rcheck(8'h82);
      u_core.wr(CFG_ADDR, 8'h0a);
      @(negedge clk);
      check("select", 20'h1, {19'h0, selOut});
      rcheck(8'h0a);
      u_core.wr(CFG_ADDR, 8'h00);
      @(negedge clk);
      check("select", 20'h0, {19'h0, selOut});
      // Immediate start, then arm sync while running.
      u_core.wr(CFG_ADDR, 8'h01);
      repeat (2) @(negedge clk);
      check("running", 20'h1, {19'h0, runOut});
      u_core.wr(CFG_ADDR, 8'h03);
      rcheck(8'h03);
      foreach (deltas[i]) begin
         u_core.wr(CFG_ADDR, 8'h02);
         rcheck(8'h03);
         stored = sleepNow;
         pulse_edge();
         rcheck(8'h02);
         sleepNow = stored + 24'(deltas[i]);
         u_core.wr(CFG_ADDR, 8'h03);
         rcheck(8'h02);
         @(negedge clk); sleepEdge = 1'b1;
         @(posedge clk);
         @(negedge clk); sleepEdge = 1'b0;
         for (n = 1; n < 100; n++) begin
            @(posedge clk); #1;
            if (strobe === 1'b1) break;
         end
         check("start delay", 20'd75, 20'(n));
         c = ((deltas[i] == 0 ? 64'd16777216 : 64'(deltas[i])) * 15625 + 8)
             / 16 + timerNow + 75;
         check("reload timer", 20'(c % period), {4'h0, relT});
         check("reload ovf", 20'(ovfNow + c / period), relO);
         rcheck(8'h03);
         check("running", 20'h1, {19'h0, runOut});
         sleepNow = sleepNow + 24'h001234;
         period = period + 16'h1111;
      end
      u_core.wr(CFG_ADDR, 8'h00);
      rcheck(8'h00);
      print_verdict();
   end
endmodule
